// File: ssc_defines.vh
/*
 * Constants for the store-align, shift and compare block: register byte
 * offsets, control fields, command codes, exception codes, reset values.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// Register byte offsets
`define SSC_OFF_CTRL 8'h00
`define SSC_OFF_CMD 8'h04
`define SSC_OFF_BASE_LO 8'h08
`define SSC_OFF_BASE_HI 8'h0C
`define SSC_OFF_SRC_LO 8'h10
`define SSC_OFF_SRC_HI 8'h14
`define SSC_OFF_PADDR 8'h18
`define SSC_OFF_RES_LO 8'h1C
`define SSC_OFF_RES_HI 8'h20
`define SSC_OFF_VADDR_LO 8'h24
`define SSC_OFF_VADDR_HI 8'h28
`define SSC_OFF_STATUS 8'h2C

// Control register fields
`define SSC_CTRL_MODE64 0
`define SSC_CTRL_CPU_BE 1
`define SSC_CTRL_MEM_BE 2
`define SSC_CTRL_REV 3
`define SSC_CTRL_PRIV_LO 4
`define SSC_CTRL_PRIV_HI 5
`define SSC_CTRL_RESET 6'h00

// Privilege levels
`define SSC_PRIV_KERNEL 2'h0
`define SSC_PRIV_SUPER 2'h1
`define SSC_PRIV_USER 2'h2

// Command register fields
`define SSC_CMD_OP_HI 2
`define SSC_CMD_OP_LO 0
`define SSC_CMD_SA_HI 12
`define SSC_CMD_SA_LO 8
`define SSC_CMD_IMM_HI 31
`define SSC_CMD_IMM_LO 16

// Operation codes
`define SSC_OP_DW_RIGHT 3'h0
`define SSC_OP_WORD_STORE 3'h1
`define SSC_OP_WORD_LEFT 3'h2
`define SSC_OP_SHIFT_LEFT 3'h3
`define SSC_OP_LT_SIGNED 3'h4
`define SSC_OP_LT_UNSIGNED 3'h5

// Access types sent to memory
`define SSC_TYPE_WORD 3'h3
`define SSC_TYPE_DWORD 3'h7

// Exception codes in the status register
`define SSC_EXC_NONE 4'h0
`define SSC_EXC_ADDR 4'h1
`define SSC_EXC_RESV 4'h2
`define SSC_EXC_TLB_REFILL 4'h3
`define SSC_EXC_TLB_INVALID 4'h4
`define SSC_EXC_TLB_MOD 4'h5
`define SSC_EXC_BUS 4'h6

// Status register fields
`define SSC_STAT_BUSY 8
`define SSC_STAT_DONE 9

// Memory fault input bits
`define SSC_FLT_REFILL 0
`define SSC_FLT_INVALID 1
`define SSC_FLT_MOD 2
`define SSC_FLT_BUS 3

`endif

// File: ssc_core.v
/*
 * Store-align, word shift and set-less-than datapath with a classic
 * Wishbone register slave and a store request port to the cache.
 * Assumes the cache answers each store request with memAck after any
 * delay, along with any fault, and writes only the lanes that the access
 * type and byte offset select. Address translation is done outside;
 * software places the translated address in the physical address register.
 */
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ssc_defines.vh"

module ssc_core (
  // Clock, reset, enable
  input wire clk,
  input wire reset,
  input wire ce,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Store request to the cache
  output reg memReq,
  output reg [2:0] memAccessType,
  output reg [31:0] memAddr,
  output reg [63:0] memData,
  input wire memAck,
  input wire [3:0] memFault
);

  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state;
  reg [5:0] ctrl;
  reg [63:0] base;
  reg [63:0] src;
  reg [31:0] paddr;
  reg [63:0] result;
  reg [63:0] vaddrReg;
  reg [3:0] excCode;
  reg done;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = dat[i*8 +: 8];
        end
      end
    end
  endfunction

  wire mode64 = ctrl[`SSC_CTRL_MODE64];
  wire cpuBigEndian = ctrl[`SSC_CTRL_CPU_BE];
  wire memBigEndian = ctrl[`SSC_CTRL_MEM_BE];
  wire reverse_endian_flag = ctrl[`SSC_CTRL_REV];
  wire [1:0] priv = ctrl[`SSC_CTRL_PRIV_HI:`SSC_CTRL_PRIV_LO];

  wire wbGo = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wbWrite = wbGo & wb_we_i;
  wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
  wire cmdTake = wbWrite & (adr == `SSC_OFF_CMD) & wb_sel_i[0] &
                 state[0];

  wire [2:0] op = wb_dat_i[`SSC_CMD_OP_HI:`SSC_CMD_OP_LO];
  wire [4:0] sa = wb_dat_i[`SSC_CMD_SA_HI:`SSC_CMD_SA_LO];
  wire [15:0] imm = wb_dat_i[`SSC_CMD_IMM_HI:`SSC_CMD_IMM_LO];

  // Extension width follows the mode
  wire [63:0] immExt = mode64 ? {{48{imm[15]}}, imm} :
                                {32'h00000000, {16{imm[15]}}, imm};
  wire [63:0] addrSum = base + immExt;
  wire [63:0] vAddr = mode64 ? addrSum : {32'h00000000, addrSum[31:0]};

  // Word shift left, zero fill, result re-extended from bit 31 in 64-bit mode, upper half zero otherwise
  wire [31:0] shifted = src[31:0] << sa;
  wire [63:0] shiftRes = mode64 ? {{32{shifted[31]}}, shifted} :
                                {32'h00000000, shifted};

  // Compares are plain relations, so no overflow can arise
  wire sltS = mode64 ? ($signed(src) < $signed(immExt)) :
              ($signed(src[31:0]) < $signed(immExt[31:0]));
  wire sltU = mode64 ? (src < immExt) :
              (src[31:0] < immExt[31:0]);

  // Physical low bits flipped by the reverse-endian flag
  wire [31:0] pRev = paddr ^ {29'h00000000, {3{reverse_endian_flag}}};

  // Right-part doubleword store
  wire [2:0] dwrByte = vAddr[2:0] ^ {3{cpuBigEndian}};
  wire [63:0] dwrData = src << {dwrByte, 3'b000};
  wire [2:0] dwrType = `SSC_TYPE_DWORD - dwrByte;
  wire [31:0] dwrAddr = memBigEndian ? pRev :
                        {pRev[31:3], 3'b000};
  wire dwrResv = ~mode64 & (priv != `SSC_PRIV_KERNEL);

  // Aligned word store
  wire [2:0] wordByte = vAddr[2:0] ^ {cpuBigEndian, 2'b00};
  wire [63:0] wordData = src << {wordByte, 3'b000};
  wire [31:0] wordAddr = paddr ^ {29'h00000000, reverse_endian_flag, 2'b00};
  wire wordAlignErr = |vAddr[1:0];

  // Left-part word store
  wire [1:0] leftByte = vAddr[1:0] ^ {2{cpuBigEndian}};
  wire [1:0] leftRest = 2'h3 - leftByte;
  wire [31:0] leftWord = src[31:0] >> {leftRest, 3'b000};
  wire leftHigh = vAddr[2] ^ cpuBigEndian;
  wire [63:0] leftData = leftHigh ? {leftWord, 32'h00000000} :
                                    {32'h00000000, leftWord};
  wire [31:0] leftAddr = memBigEndian ? pRev :
                         {pRev[31:2], 2'b00};

  // Control word after byte-lane merge, cut to its six bits
  wire [31:0] ctrlNew = merge({26'h0000000, ctrl}, wb_dat_i, wb_sel_i);

  reg [31:0] rdData;
  always @* begin
    case (adr)
      `SSC_OFF_CTRL: rdData = {26'h0000000, ctrl};
      `SSC_OFF_BASE_LO: rdData = base[31:0];
      `SSC_OFF_BASE_HI: rdData = base[63:32];
      `SSC_OFF_SRC_LO: rdData = src[31:0];
      `SSC_OFF_SRC_HI: rdData = src[63:32];
      `SSC_OFF_PADDR: rdData = paddr;
      `SSC_OFF_RES_LO: rdData = result[31:0];
      `SSC_OFF_RES_HI: rdData = result[63:32];
      `SSC_OFF_VADDR_LO: rdData = vaddrReg[31:0];
      `SSC_OFF_VADDR_HI: rdData = vaddrReg[63:32];
      `SSC_OFF_STATUS: rdData = {22'h000000, done, state[1], 4'h0,
                                 excCode};
      default: rdData = 32'h00000000;
    endcase
  end

  // Fault priority on a store answer
  reg [3:0] faultCode;
  always @* begin
    if (memFault[`SSC_FLT_REFILL]) begin
      faultCode = `SSC_EXC_TLB_REFILL;
    end else if (memFault[`SSC_FLT_INVALID]) begin
      faultCode = `SSC_EXC_TLB_INVALID;
    end else if (memFault[`SSC_FLT_MOD]) begin
      faultCode = `SSC_EXC_TLB_MOD;
    end else if (memFault[`SSC_FLT_BUS]) begin
      faultCode = `SSC_EXC_BUS;
    end else begin
      faultCode = `SSC_EXC_NONE;
    end
  end

  // Register bus: one wait state, answer on every address
  always @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl <= `SSC_CTRL_RESET;
      base <= 64'h0000000000000000;
      src <= 64'h0000000000000000;
      paddr <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= wbGo;
      wb_dat_o <= wbGo ? rdData : 32'h00000000;
      // Byte lanes merge into the addressed word
      if (wbWrite) begin
        case (adr)
          `SSC_OFF_CTRL: begin
            ctrl <= ctrlNew[5:0];
          end
          `SSC_OFF_BASE_LO: begin
            base[31:0] <= merge(base[31:0], wb_dat_i, wb_sel_i);
          end
          `SSC_OFF_BASE_HI: begin
            base[63:32] <= merge(base[63:32], wb_dat_i, wb_sel_i);
          end
          `SSC_OFF_SRC_LO: begin
            src[31:0] <= merge(src[31:0], wb_dat_i, wb_sel_i);
          end
          `SSC_OFF_SRC_HI: begin
            src[63:32] <= merge(src[63:32], wb_dat_i, wb_sel_i);
          end
          `SSC_OFF_PADDR: begin
            paddr <= merge(paddr, wb_dat_i, wb_sel_i);
          end
          default: ;
        endcase
      end
    end
  end

  // Command execution and store requests
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      result <= 64'h0000000000000000;
      vaddrReg <= 64'h0000000000000000;
      excCode <= `SSC_EXC_NONE;
      done <= 1'b0;
      memReq <= 1'b0;
      memAccessType <= 3'h0;
      memAddr <= 32'h00000000;
      memData <= 64'h0000000000000000;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          // A busy engine ignores commands until the store is answered
          if (cmdTake) begin
            vaddrReg <= vAddr;
            excCode <= `SSC_EXC_NONE;
            done <= 1'b1;
            case (op)
              `SSC_OP_DW_RIGHT: begin
                // No alignment check here
                if (dwrResv) begin
                  excCode <= `SSC_EXC_RESV;
                end else begin
                  memReq <= 1'b1;
                  memAccessType <= dwrType;
                  memAddr <= dwrAddr;
                  memData <= dwrData;
                  done <= 1'b0;
                  state <= ST_WAIT;
                end
              end
              `SSC_OP_WORD_STORE: begin
                if (wordAlignErr) begin
                  excCode <= `SSC_EXC_ADDR;
                end else begin
                  memReq <= 1'b1;
                  memAccessType <= `SSC_TYPE_WORD;
                  memAddr <= wordAddr;
                  memData <= wordData;
                  done <= 1'b0;
                  state <= ST_WAIT;
                end
              end
              `SSC_OP_WORD_LEFT: begin
                memReq <= 1'b1;
                memAccessType <= {1'b0, leftByte};
                memAddr <= leftAddr;
                memData <= leftData;
                done <= 1'b0;
                state <= ST_WAIT;
              end
              // ALU results land at the command edge
              `SSC_OP_SHIFT_LEFT: begin
                result <= shiftRes;
              end
              `SSC_OP_LT_SIGNED: begin
                result <= {63'h0, sltS};
              end
              `SSC_OP_LT_UNSIGNED: begin
                result <= {63'h0, sltU};
              end
              default: result <= result;
            endcase
          end
        end
        ST_WAIT: begin
          // The cache keeps to the lanes it is given
          if (memAck) begin
            memReq <= 1'b0;
            excCode <= faultCode;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          memReq <= 1'b0;
        end
      endcase
    end
  end

endmodule // ssc_core

// File: ssc_core_chk.sv
/* Port timing checks for ssc_core.
   Assumes a bind to ssc_core with ce held high. */
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_core_chk (
  // Clock, reset, enable
  input wire clk,
  input wire reset,
  input wire ce,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Store port
  input wire memReq,
  input wire memAck,
  input wire [2:0] memAccessType,
  input wire [31:0] memAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence s_cmd;
    s_take ##0 wb_we_i && wb_sel_i[0] && !memReq &&
      wb_adr_i[7:2] == (`SSC_OFF_CMD >> 2);
  endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_hold;
    memReq && !memAck |=> memReq && $stable(memAccessType) &&
      $stable(memAddr);
  endproperty
  property p_drop; memReq && memAck |=> !memReq; endproperty
  property p_left;
    s_cmd ##0 wb_dat_i[2:0] == `SSC_OP_WORD_LEFT |=>
      memReq && !memAccessType[2];
  endproperty
  property p_alu; s_cmd ##0 wb_dat_i[2:0] >= `SSC_OP_SHIFT_LEFT |=> !memReq;
  endproperty
  property p_req; $rose(memReq) |-> $past(wb_stb_i && wb_we_i);
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_pulse: assert property (p_pulse) else $error("ack too long");
  a_cause: assert property (p_cause) else $error("ack unasked");
  a_idle: assert property (p_idle) else $error("data without ack");
  a_hold: assert property (p_hold) else $error("request moved");
  a_drop: assert property (p_drop) else $error("request kept");
  a_left: assert property (p_left) else $error("bad left store");
  a_alu: assert property (p_alu) else $error("alu stored");
  a_req: assert property (p_req) else $error("request uncaused");
endmodule // ssc_core_chk

// File: ssc_mem_model.sv
/* Cache model: answers stores after a set delay.
   Assumes the bench sets waitCycles and faultIn. */
`timescale 1ns/1ps
module ssc_mem_model (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Store port
  input wire memReq,
  input wire [2:0] memAccessType,
  input wire [31:0] memAddr,
  input wire [63:0] memData,
  output reg memAck,
  output reg [3:0] memFault,
  // Bench controls
  input wire [3:0] waitCycles,
  input wire [3:0] faultIn
);
  reg [3:0] cnt;
  reg [63:0] mem;
  reg [2:0] capType;
  reg [31:0] capAddr;
  reg [63:0] capData;
  integer nStores;
  integer k;
  always @(posedge clk) begin
    if (reset) begin
      memAck <= 1'b0;
      memFault <= 4'h0;
      cnt <= 4'h0;
      nStores <= 0;
    end else if (memReq && !memAck) begin
      if (cnt >= waitCycles) begin
        memAck <= 1'b1;
        memFault <= faultIn;
        cnt <= 4'h0;
        nStores <= nStores + 1;
        capType <= memAccessType;
        capAddr <= memAddr;
        capData <= memData;
        for (k = 0; k < 8; k = k + 1)
          if (((k - memAddr[2:0]) & 7) <= memAccessType)
            mem[8*k +: 8] <= memData[8*k +: 8];
      end else
        cnt <= cnt + 4'h1;
    end else begin
      memAck <= 1'b0;
      // Fault lines are not valid without ack
      memFault <= ~memFault;
    end
  end
endmodule // ssc_mem_model

// File: ssc_core_tb_top.sv
/* Bench for ssc_core with the cache model.
   Assumes header, design, checker and model are compiled first. */
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_core_tb_top;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0;
  reg [3:0] waitCycles = 4'h0;
  reg [3:0] faultIn = 4'h0;
  wire [31:0] rdat;
  wire ack, memReq, memAck;
  wire [2:0] memAccessType;
  wire [31:0] memAddr;
  wire [63:0] memData;
  wire [3:0] memFault;
  integer fails = 0;
  integer total_checks = 0;
  reg [63:0] q, st, res;
  reg [2:0] k;
  always #50 clk = ~clk;
  ssc_core dut (.clk(clk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .memReq(memReq),
    .memAccessType(memAccessType), .memAddr(memAddr), .memData(memData),
    .memAck(memAck), .memFault(memFault));
  ssc_mem_model mem (.clk(clk), .reset(reset), .memReq(memReq),
    .memAccessType(memAccessType), .memAddr(memAddr), .memData(memData),
    .memAck(memAck), .memFault(memFault), .waitCycles(waitCycles),
    .faultIn(faultIn));
  task chk(input [63:0] e, input [63:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        $display("[ERR] %0t exp=%h got=%h", $time, e, g);
        fails = fails + 1;
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = {32'h0, rdat};
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task run(input [5:0] c, input [2:0] op, input [4:0] sa, input [15:0] i,
    input [63:0] s);
    begin
      wb(1'b1, `SSC_OFF_CTRL, {26'h0, c});
      wb(1'b1, `SSC_OFF_BASE_LO, 32'h1000);
      wb(1'b1, `SSC_OFF_BASE_HI, 32'h0);
      wb(1'b1, `SSC_OFF_SRC_LO, s[31:0]);
      wb(1'b1, `SSC_OFF_SRC_HI, s[63:32]);
      wb(1'b1, `SSC_OFF_PADDR, 32'h2003);
      wb(1'b1, `SSC_OFF_CMD, {i, 3'h0, sa, 5'h00, op});
      q = 64'h0;
      while (q[`SSC_STAT_DONE] !== 1'b1) wb(1'b0, `SSC_OFF_STATUS, 32'h0);
      st = q;
      wb(1'b0, `SSC_OFF_RES_LO, 32'h0);
      res[31:0] = q[31:0];
      wb(1'b0, `SSC_OFF_RES_HI, 32'h0);
      res[63:32] = q[31:0];
    end
  endtask
  task slt(input [5:0] c, input [63:0] s, input [15:0] i, input [1:0] e);
    begin
      run(c, `SSC_OP_LT_SIGNED, 5'h00, i, s);
      chk({63'h0, e[1]}, res);
      run(c, `SSC_OP_LT_UNSIGNED, 5'h00, i, s);
      chk({63'h0, e[0]}, res);
    end
  endtask
  task sto(input [5:0] c, input [2:0] op, input [15:0] i, input [3:0] ex,
    input [2:0] ty, input [31:0] ea, input [63:0] d);
    reg [31:0] n;
    begin
      n = mem.nStores;
      run(c, op, 5'h00, i, 64'h1122334455667788);
      wb(1'b0, `SSC_OFF_VADDR_LO, 32'h0);
      chk({32'h0, 32'h1000 + {{16{i[15]}}, i}}, q);
      chk({60'h0, ex}, {60'h0, st[3:0]});
      if (ex == `SSC_EXC_ADDR || ex == `SSC_EXC_RESV)
        chk({32'h0, n}, {32'h0, mem.nStores});
      else begin
        chk({61'h0, ty}, {61'h0, mem.capType});
        chk({32'h0, ea}, {32'h0, mem.capAddr});
        chk(d, mem.capData);
      end
    end
  endtask
  task results;
    begin
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    results;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, 8'hFC, 32'h0);
    chk(64'h0, q);
    run(6'h01, `SSC_OP_SHIFT_LEFT, 5'h01, 16'h0, 64'h12345678C0000001);
    chk(64'hFFFFFFFF80000002, res);
    run(6'h01, `SSC_OP_SHIFT_LEFT, 5'h00, 16'h0, 64'h12345678C0000001);
    chk(64'hFFFFFFFFC0000001, res);
    run(6'h00, `SSC_OP_SHIFT_LEFT, 5'h04, 16'h0, 64'h0FFFFFFF);
    chk(64'hFFFFFFF0, res);
    slt(6'h01, 64'hFFFFFFFFFFFFFFFE, 16'hFFFF, 2'h3);
    slt(6'h01, 64'h1, 16'hFFFF, 2'h1);
    slt(6'h00, 64'h80000000, 16'h0001, 2'h2);
    slt(6'h01, 64'h80000000, 16'h0001, 2'h0);
    sto(6'h05, `SSC_OP_DW_RIGHT, 16'hFFFB, 4'h0, 3'h4, 32'h2003,
      64'h4455667788000000);
    sto(6'h0A, `SSC_OP_DW_RIGHT, 16'hFFFB, 4'h0, 3'h3, 32'h2000,
      64'h5566778800000000);
    sto(6'h20, `SSC_OP_DW_RIGHT, 16'h0, `SSC_EXC_RESV, 3'h0, 32'h0,
      64'h0);
    sto(6'h10, `SSC_OP_DW_RIGHT, 16'h0, `SSC_EXC_RESV, 3'h0, 32'h0,
      64'h0);
    sto(6'h01, `SSC_OP_WORD_STORE, 16'h0002, `SSC_EXC_ADDR, 3'h0, 32'h0,
      64'h0);
    sto(6'h01, `SSC_OP_WORD_STORE, 16'h0001, `SSC_EXC_ADDR, 3'h0, 32'h0,
      64'h0);
    sto(6'h00, `SSC_OP_WORD_LEFT, 16'h0001, 4'h0, 3'h1, 32'h2000,
      64'h5566);
    sto(6'h02, `SSC_OP_WORD_LEFT, 16'h0001, 4'h0, 3'h2, 32'h2000,
      64'h0055667700000000);
    waitCycles <= 4'h5;
    for (k = 0; k < 5; k = k + 1) begin
      faultIn <= (k == 0) ? 4'h0 : 4'h1 << (k - 1);
      sto(6'h01, `SSC_OP_WORD_STORE, 16'h0004,
        (k == 0) ? 4'h0 : 4'h2 + k, 3'h3,
        32'h2003, 64'h5566778800000000);
    end
    results;
  end
endmodule // ssc_core_tb_top
bind ssc_core ssc_core_chk u_chk (.clk(clk), .reset(reset), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .memReq(memReq),
  .memAck(memAck), .memAccessType(memAccessType), .memAddr(memAddr));
